// file: dv/gccr_regs_assertions.sv
// checker for the global configuration register bank
module gccr_regs_chk
	import gccr_pkg::*;
(
	// clock and resets
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic STANDBY_POR,
	input wire logic HARD_RESET,
	input wire logic SOFT_RESET,
	input wire logic NUMBERING_STRAP,
	// access
	input wire logic CONFIG_MODE,
	input wire logic DATA_WR,
	input wire logic [7:0] INDEX,
	input wire logic [7:0] DATA_IN,
	input wire logic [7:0] DATA_OUT,
	// controls
	input wire logic FLOPPY_CONTROLLER_EN,
	input wire logic PARALLEL_EN,
	input wire logic SERIAL1_EN,
	input wire logic SERIAL2_EN,
	input wire logic PLL_ON,
	input wire logic OSC_ON,
	input wire logic BAUD_GENERATOR_CLK_EN,
	input wire logic ADDR_QUAL_16,
	input wire logic NUMBERING_SCHEME_SELECT,
	input wire logic [15:0] CONFIG_PORT_ADDRESS
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);
	// a reset can beat a write, so only clean writes count
	wire logic wr_ok = CONFIG_MODE && DATA_WR && !HARD_RESET && !STANDBY_POR && !SOFT_RESET;
	sequence s_clk_wr; wr_ok && INDEX == IDX_OSC; endsequence
	property p_pll; s_clk_wr |=> PLL_ON == !$past(DATA_IN[1]); endproperty
	a_pll: assert property (p_pll) else $error("pll control wrong");
	property p_stop; s_clk_wr |=> (OSC_ON && BAUD_GENERATOR_CLK_EN) == ($past(DATA_IN[3:2]) != 2'b11); endproperty
	a_stop: assert property (p_stop) else $error("clock stop wrong");
	property p_q16; s_clk_wr |=> ADDR_QUAL_16 == $past(DATA_IN[6]); endproperty
	a_q16: assert property (p_q16) else $error("qualification wrong");
	property p_pwr; wr_ok && INDEX == IDX_POWER |=> {SERIAL2_EN, SERIAL1_EN, PARALLEL_EN, FLOPPY_CONTROLLER_EN}
		== {$past(DATA_IN[5]), $past(DATA_IN[4]), $past(DATA_IN[3]), $past(DATA_IN[0])}; endproperty
	a_pwr: assert property (p_pwr) else $error("power enables wrong");
	property p_lo; wr_ok && INDEX == IDX_ADDR_LOW |=> CONFIG_PORT_ADDRESS[7:0] == ($past(DATA_IN) & 8'hFE); endproperty
	a_lo: assert property (p_lo) else $error("address low wrong");
	property p_hi; wr_ok && INDEX == IDX_ADDR_HIGH |=> CONFIG_PORT_ADDRESS[15:8] == $past(DATA_IN); endproperty
	a_hi: assert property (p_hi) else $error("address high wrong");
	property p_soft; SOFT_RESET && !HARD_RESET && !STANDBY_POR && !DATA_WR |=> !FLOPPY_CONTROLLER_EN
		&& $stable(CONFIG_PORT_ADDRESS) && $stable(ADDR_QUAL_16); endproperty
	a_soft: assert property (p_soft) else $error("soft reset wrong");
	property p_hard; HARD_RESET |=> CONFIG_PORT_ADDRESS == 16'h002E && NUMBERING_SCHEME_SELECT == $past(NUMBERING_STRAP);
	endproperty
	a_hard: assert property (p_hard) else $error("hard reset wrong");
	property p_zero; !CONFIG_MODE || INDEX == IDX_RSVD_23 || INDEX == IDX_RSVD_25 |=> DATA_OUT == 8'h00; endproperty
	a_zero: assert property (p_zero) else $error("read not zero");
endmodule : gccr_regs_chk
bind gccr_regs gccr_regs_chk gccr_regs_chk_i (.*);

// file: dv/gccr_regs_tb.sv
// self-checking bench for the global configuration register bank
module gccr_regs_tb
	import gccr_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic CLK_SYS = 0, RST_N = 0, STANDBY_POR = 0, HARD_RESET = 0, SOFT_RESET = 0, NUMBERING_STRAP = 0;
	logic CONFIG_MODE = 1, DATA_WR = 0, look = 0, FLOPPY_CONTROLLER_EN, PARALLEL_EN, SERIAL1_EN, SERIAL2_EN;
	logic PLL_ON, OSC_ON, BAUD_GENERATOR_CLK_EN, ADDR_QUAL_16, NUMBERING_SCHEME_SELECT;
	logic [7:0] INDEX = 0, DATA_IN = 0, DATA_OUT, sd = 8'h47, ix;
	logic [15:0] CONFIG_PORT_ADDRESS;
	logic [7:0] mdl [0:255], msk [0:255], q [$];
	int error_cnt = 0, cmp_count = 0;
	gccr_regs gccr_regs_i (.*);
	initial forever #5 CLK_SYS = ~CLK_SYS;
	function automatic logic [7:0] lf(logic [7:0] s); return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]}; endfunction : lf
	task automatic check(logic [7:0] seen, logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : check
	task automatic out_chk();
		check({2'h0, SERIAL2_EN, SERIAL1_EN, PARALLEL_EN, 2'h0, FLOPPY_CONTROLLER_EN}, mdl[IDX_POWER]);
		check({6'h00, PLL_ON, ADDR_QUAL_16}, {6'h00, !mdl[IDX_OSC][1], mdl[IDX_OSC][6]});
		check({6'h00, OSC_ON, BAUD_GENERATOR_CLK_EN}, {6'h00, {2{mdl[IDX_OSC][3:2] != 2'h3}}});
		check(CONFIG_PORT_ADDRESS[15:8], mdl[IDX_ADDR_HIGH]);
		check(CONFIG_PORT_ADDRESS[7:0], mdl[IDX_ADDR_LOW]);
		check({7'h00, NUMBERING_SCHEME_SELECT}, mdl[IDX_NUMBERING]);
	endtask : out_chk
	task automatic complete_run();
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : complete_run
	task automatic wr(logic [7:0] i, logic [7:0] d);
		@(posedge CLK_SYS) #2 {INDEX, DATA_IN, DATA_WR} = {i, d, 1'b1};
		if (CONFIG_MODE) mdl[i] = d & msk[i];
		@(posedge CLK_SYS) #2 DATA_WR = 0;
	endtask : wr
	task automatic rd(logic [7:0] i);
		@(posedge CLK_SYS) #2 {INDEX, look} = {i, 1'b1};
		q.push_back(CONFIG_MODE ? mdl[i] : 8'h00);
		@(posedge CLK_SYS) #2 look = 0;
	endtask : rd
	task automatic all_rd();
		for (int i = 8'h20; i < 8'h30; i++) rd(8'(i));
		out_chk();
		$display("test end at %0t", $time);
	endtask : all_rd
	// 0 soft, 1 hard, 2 standby power-on
	task automatic rst(int k);
		@(posedge CLK_SYS) #2 {SOFT_RESET, HARD_RESET, STANDBY_POR} = {k == 0, k == 1, k == 2};
		mdl[IDX_POWER] = RST_POWER;
		if (k > 0) {mdl[IDX_OSC], mdl[IDX_NUMBERING]} = {RST_OSC, 7'h00, NUMBERING_STRAP};
		if (k == 1) {mdl[IDX_ADDR_LOW], mdl[IDX_ADDR_HIGH]} = {RST_ADDR_LOW, RST_ADDR_HIGH};
		if (k == 2) mdl[IDX_TEST_A] = RST_TEST_A;
		@(posedge CLK_SYS) #2 {SOFT_RESET, HARD_RESET, STANDBY_POR} = 3'h0;
	endtask : rst
	always @(posedge CLK_SYS) if (look) begin
		#1 check(DATA_OUT, q.size() ? q.pop_front() : 8'hXX);
	end
	initial begin
		foreach (mdl[i]) {mdl[i], msk[i]} = 16'h0000;
		{msk[IDX_POWER], msk[IDX_OSC], msk[IDX_ADDR_LOW], msk[IDX_ADDR_HIGH], msk[IDX_TEST_A], msk[IDX_NUMBERING]}
			= {MASK_POWER, MASK_OSC, MASK_ADDR_LOW, 16'hFFFF, MASK_NUMBERING};
		{mdl[IDX_OSC], mdl[IDX_ADDR_LOW]} = {RST_OSC, RST_ADDR_LOW};
		repeat (4) @(posedge CLK_SYS);
		#2 RST_N = 1;
		all_rd();
		for (int n = 0; n < 60; n++) begin
			sd = lf(sd);
			ix = {4'h2, sd[3:0]};
			sd = lf(sd);
			if (ix != IDX_TEST_A) wr(ix, ix == IDX_OSC ? sd & 8'hCF : sd);
			rd(ix);
			out_chk();
		end
		$display("test end at %0t", $time);
		@(posedge CLK_SYS) #2 CONFIG_MODE = 0;
		wr(IDX_POWER, 8'hFF);
		rd(IDX_POWER);
		out_chk();
		$display("test end at %0t", $time);
		@(posedge CLK_SYS) #2 CONFIG_MODE = 1;
		wr(IDX_POWER, 8'hFF);
		rst(0);
		all_rd();
		NUMBERING_STRAP = 1;
		rst(1);
		all_rd();
		rst(2);
		all_rd();
		complete_run();
	end
	initial begin
		repeat (20000) @(posedge CLK_SYS);
		error_cnt++;
		complete_run();
	end
endmodule : gccr_regs_tb

// file: logic/gccr_pkg.sv
// constants for the global chip configuration register bank
package gccr_pkg;
	localparam logic [7:0] IDX_POWER = 8'h22;
	localparam logic [7:0] IDX_RSVD_23 = 8'h23;
	localparam logic [7:0] IDX_OSC = 8'h24;
	localparam logic [7:0] IDX_RSVD_25 = 8'h25;
	localparam logic [7:0] IDX_ADDR_LOW = 8'h26;
	localparam logic [7:0] IDX_ADDR_HIGH = 8'h27;
	localparam logic [7:0] IDX_TEST_A = 8'h28;
	localparam logic [7:0] IDX_NUMBERING = 8'h29;

	localparam logic [7:0] RST_POWER = 8'h00;
	localparam logic [7:0] RST_OSC = 8'h44;
	localparam logic [7:0] RST_ADDR_LOW = 8'h2E;
	localparam logic [7:0] RST_ADDR_HIGH = 8'h00;
	localparam logic [7:0] RST_TEST_A = 8'h00;

	// writable bits per register
	localparam logic [7:0] MASK_POWER = 8'h39;
	localparam logic [7:0] MASK_OSC = 8'h7E;
	localparam logic [7:0] MASK_ADDR_LOW = 8'hFE;
	localparam logic [7:0] MASK_NUMBERING = 8'h01;

	localparam int POS_FLOPPY = 0;
	localparam int POS_PARALLEL = 3;
	localparam int POS_SERIAL1 = 4;
	localparam int POS_SERIAL2 = 5;
	localparam int POS_PLL_OFF = 1;
	localparam int POS_OSC_LO = 2;
	localparam int POS_OSC_HI = 3;
	localparam int POS_ADDR16 = 6;
	localparam logic [1:0] OSC_STOPPED = 2'b11;
endpackage : gccr_pkg

// file: logic/gccr_regs.sv
// global chip configuration registers at indices 0x22 to 0x29

//////////////////////////////////////////////////////////////////////////////
module gccr_regs
	import gccr_pkg::*;
(
	// clock and resets
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic STANDBY_POR,
	input wire logic HARD_RESET,
	input wire logic SOFT_RESET,
	// strap, sampled on each reset that loads the numbering select
	input wire logic NUMBERING_STRAP,
	// index/data access
	input wire logic CONFIG_MODE,
	input wire logic [7:0] INDEX,
	input wire logic DATA_WR,
	input wire logic [7:0] DATA_IN,
	output logic [7:0] DATA_OUT,
	// function controls
	output logic FLOPPY_CONTROLLER_EN,
	output logic PARALLEL_EN,
	output logic SERIAL1_EN,
	output logic SERIAL2_EN,
	output logic PLL_ON,
	output logic OSC_ON,
	output logic BAUD_GENERATOR_CLK_EN,
	output logic ADDR_QUAL_16,
	output logic [15:0] CONFIG_PORT_ADDRESS,
	output logic NUMBERING_SCHEME_SELECT
);
	//////////////////////////////////////////////////////////////////////////
	// storage
	logic [7:0] power_reg;
	logic [7:0] osc_reg;
	logic [7:0] addr_low_reg;
	logic [7:0] addr_high_reg;
	logic [7:0] test_a_reg;
	logic [7:0] numbering_reg;

	// host access
	logic wr;
	logic [7:0] rd_next;

	// one write enable per implemented index
	logic we_power;
	logic we_osc;
	logic we_addr_low;
	logic we_addr_high;
	logic we_test_a;
	logic we_numbering;

	// reset terms; each register group honours its own reset sources
	logic init_power;
	logic init_osc;
	logic init_addr;
	logic init_test_a;
	logic init_numbering;

	// decoded controls
	logic osc_stop;
	logic [3:0] func_en;
	// bit positions of the four function enables, in output order
	localparam int FUNC_POS [4] = '{POS_FLOPPY, POS_PARALLEL, POS_SERIAL1, POS_SERIAL2};

	//////////////////////////////////////////////////////////////////////////
	// host port is dead outside configuration mode
	assign wr = DATA_WR && CONFIG_MODE;

	// full 8-bit compare, so aliases of these indices never hit
	assign we_power = wr && (INDEX == IDX_POWER);
	assign we_osc = wr && (INDEX == IDX_OSC);
	assign we_addr_low = wr && (INDEX == IDX_ADDR_LOW);
	assign we_addr_high = wr && (INDEX == IDX_ADDR_HIGH);
	assign we_test_a = wr && (INDEX == IDX_TEST_A);
	assign we_numbering = wr && (INDEX == IDX_NUMBERING);

	// soft reset only reaches the power enables
	assign init_power = !RST_N || STANDBY_POR || HARD_RESET || SOFT_RESET;
	assign init_osc = !RST_N || STANDBY_POR || HARD_RESET;
	// standby power-on alone does not touch the port address
	assign init_addr = !RST_N || HARD_RESET;
	// hard reset leaves the test register as it was
	assign init_test_a = !RST_N || STANDBY_POR;
	assign init_numbering = !RST_N || STANDBY_POR || HARD_RESET;

	//////////////////////////////////////////////////////////////////////////
	// power enables: cleared by every reset kind
	always_ff @(posedge CLK_SYS) begin
		if (init_power) begin
			power_reg <= RST_POWER;
		end else if (we_power) begin
			power_reg <= DATA_IN & MASK_POWER;
		end
	end

	// soft reset is not a term here
	always_ff @(posedge CLK_SYS) begin
		if (init_osc) begin
			osc_reg <= RST_OSC;
		end else if (we_osc) begin
			// bits 7 and 0 kept zero; 5:4 stay writable, software is asked to write zero there anyway
			osc_reg <= DATA_IN & MASK_OSC;
		end
	end

	// bit 0 forced low so the port address stays even
	always_ff @(posedge CLK_SYS) begin
		if (init_addr) begin
			addr_low_reg <= RST_ADDR_LOW;
		end else if (we_addr_low) begin
			addr_low_reg <= DATA_IN & MASK_ADDR_LOW;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (init_addr) begin
			addr_high_reg <= RST_ADDR_HIGH;
		end else if (we_addr_high) begin
			addr_high_reg <= DATA_IN;
		end
	end

	// test register stored but drives nothing; writing it is discouraged
	always_ff @(posedge CLK_SYS) begin
		if (init_test_a) begin
			test_a_reg <= RST_TEST_A;
		end else if (we_test_a) begin
			test_a_reg <= DATA_IN;
		end
	end

	// strap sampled synchronously while a loading reset is held
	always_ff @(posedge CLK_SYS) begin
		if (init_numbering) begin
			numbering_reg <= {7'h00, NUMBERING_STRAP};
		end else if (we_numbering) begin
			numbering_reg <= DATA_IN & MASK_NUMBERING;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// read mux: full 8-bit index compare, everything else reads zero
	always_comb begin
		rd_next = 8'h00;
		case (INDEX)
			IDX_POWER: begin
				rd_next = power_reg;
			end
			IDX_OSC: begin
				rd_next = osc_reg;
			end
			IDX_ADDR_LOW: begin
				rd_next = addr_low_reg;
			end
			IDX_ADDR_HIGH: begin
				rd_next = addr_high_reg;
			end
			IDX_TEST_A: begin
				rd_next = test_a_reg;
			end
			IDX_NUMBERING: begin
				rd_next = numbering_reg;
			end
			IDX_RSVD_23, IDX_RSVD_25: begin
				rd_next = 8'h00;
			end
			default: begin
				rd_next = 8'h00;
			end
		endcase
	end

	// registered: the host sees the byte one cycle after the index settles
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			DATA_OUT <= 8'h00;
		end else begin
			DATA_OUT <= CONFIG_MODE ? rd_next : 8'h00;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// one enable bit per function, taken straight from the power register
	genvar g;
	for (g = 0; g < 4; g++) begin : g_func
		assign func_en[g] = power_reg[FUNC_POS[g]];
	end
	assign FLOPPY_CONTROLLER_EN = func_en[0];
	assign PARALLEL_EN = func_en[1];
	assign SERIAL1_EN = func_en[2];
	assign SERIAL2_EN = func_en[3];

	// oscillator and baud clock stop together; there is no separate control
	assign osc_stop = osc_reg[POS_OSC_HI:POS_OSC_LO] == OSC_STOPPED;
	assign PLL_ON = !osc_reg[POS_PLL_OFF];
	assign OSC_ON = !osc_stop;
	assign BAUD_GENERATOR_CLK_EN = !osc_stop;
	// reset value already sets this; software should keep it set
	assign ADDR_QUAL_16 = osc_reg[POS_ADDR16];
	assign CONFIG_PORT_ADDRESS = {addr_high_reg, addr_low_reg};
	assign NUMBERING_SCHEME_SELECT = numbering_reg[0];
endmodule : gccr_regs
